// ==== rtl/cmbl_pkg.sv ====
// Package with layout constants for the CAN message buffer identifier words
// ==========================================================================
package cmbl_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 11;
  localparam int MEM_WORDS = 2048;
  localparam int SID_W = 11;
  localparam int SID_LSB = 2;
  localparam int SID_MSB = 12;
  localparam int REMOTE_BIT = 1;
  localparam int EXT_BIT = 0;
  localparam int EIDU_W = 12;
  localparam int EIDU_MSB = 11;
  localparam logic [15:0] W0_MASK = 16'h1FFF;
  localparam logic [15:0] W1_MASK = 16'h0FFF;
  localparam logic [10:0] BASE_RESET = 11'h000;
  localparam logic [10:0] SIZE_RESET = 11'h001;
  localparam logic [10:0] WORDS_PER_BUF = 11'h008;
endpackage

// ==== rtl/cmbl_decode.sv ====
// Field decoder for the two identifier words of one message buffer
`timescale 1ns/1ps
module cmbl_decode (
  input wire logic [15:0] word0_in,
  input wire logic [15:0] word1_in,
  output logic [10:0] sid_out,
  output logic remote_out,
  output logic ext_out,
  output logic [11:0] eidu_out
);
  // ==========================================================
  // Field extraction
  assign sid_out = word0_in[cmbl_pkg::SID_MSB:cmbl_pkg::SID_LSB];
  assign remote_out = word0_in[cmbl_pkg::REMOTE_BIT];
  assign ext_out = word0_in[cmbl_pkg::EXT_BIT];
  assign eidu_out = word1_in[cmbl_pkg::EIDU_MSB:0];
endmodule

// ==== rtl/cmbl_top.sv ====
// Shared DMA memory holding CAN message buffers, with identifier fetch
`timescale 1ns/1ps
// How the block is used:
// - Software owns the buffer memory and writes whole words straight into it.
// - Software also loads the area base and the number of buffers; the fetch
//   path only follows those two values and never checks them for overlap.
// - The controller side asks for one buffer at a time and gets the split
//   identifier fields two edges later, together with a done pulse.
// - A request outside the configured area raises an error pulse with done
//   and leaves the last good identifier fields standing.
// - Addresses wrap at the top of memory, so an area may straddle the end.
// Limitation: a write and a fetch of the same word in one cycle return the
// old contents; software must leave one cycle between them.
module cmbl_top (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic sw_we_in,
  input wire logic sw_re_in,
  input wire logic [10:0] sw_addr_in,
  input wire logic [15:0] sw_wdata_in,
  output logic [15:0] sw_rdata_out,
  input wire logic area_we_in,
  input wire logic [10:0] area_base_in,
  input wire logic [10:0] area_bufs_in,
  input wire logic fetch_in,
  input wire logic [10:0] fetch_buf_in,
  output logic fetch_done_out,
  output logic fetch_err_out,
  output logic [10:0] standard_identifier_out,
  output logic remote_out,
  output logic ext_out,
  output logic [11:0] extended_identifier_upper_out
);
  // ==========================================================
  // Storage: plain memory, not a register file
  // One array holds every buffer; no per-buffer flops are kept, which keeps
  // the area cheap but means only one buffer can be fetched per cycle.
  logic [15:0] mem [0:2047];
  logic [10:0] base_reg;
  logic [10:0] bufs_reg;
  logic [15:0] rdata_reg;
  logic [15:0] w0_reg;
  logic [15:0] w1_reg;
  logic done_reg;
  logic err_reg;
  logic [10:0] sid_w;
  logic remote_w;
  logic ext_w;
  logic [11:0] eidu_w;
  logic [10:0] w0_addr;
  logic [10:0] w1_addr;
  logic fetch_ok;
  logic [21:0] off_full;

  // ==========================================================
  // Address of identifier words inside the software-chosen area
  assign off_full = {11'h000, fetch_buf_in} * {11'h000, cmbl_pkg::WORDS_PER_BUF};
  assign w0_addr = 11'(base_reg + off_full[10:0]);
  assign w1_addr = 11'(w0_addr + 11'h001);
  assign fetch_ok = fetch_in && (fetch_buf_in < bufs_reg);

  // Area configuration, written by software at any time
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      base_reg <= cmbl_pkg::BASE_RESET;
      bufs_reg <= cmbl_pkg::SIZE_RESET;
    end else if (area_we_in) begin
      base_reg <= area_base_in;
      bufs_reg <= area_bufs_in;
    end
  end

  // Software writes buffers directly; storage has no reset, contents unknown
  always_ff @(posedge clk_in) begin
    if (sw_we_in) begin
      mem[sw_addr_in] <= sw_wdata_in;
    end
  end

  // Software read-back of raw memory
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_reg <= 16'h0000;
    end else if (sw_re_in) begin
      rdata_reg <= mem[sw_addr_in];
    end
  end

  // Controller fetch; unimplemented bits are forced to zero on the way in
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      w0_reg <= 16'h0000;
      w1_reg <= 16'h0000;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      done_reg <= fetch_in;
      err_reg <= fetch_in && !fetch_ok;
      if (fetch_ok) begin
        w0_reg <= mem[w0_addr] & cmbl_pkg::W0_MASK;
        w1_reg <= mem[w1_addr] & cmbl_pkg::W1_MASK;
      end
    end
  end

  // ==========================================================
  // Field split
  cmbl_decode u_decode (
    .word0_in(w0_reg),
    .word1_in(w1_reg),
    .sid_out(sid_w),
    .remote_out(remote_w),
    .ext_out(ext_w),
    .eidu_out(eidu_w)
  );

  // Output flops, one cycle behind the fetched words
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      standard_identifier_out <= 11'h000;
      remote_out <= 1'b0;
      ext_out <= 1'b0;
      extended_identifier_upper_out <= 12'h000;
      fetch_done_out <= 1'b0;
      fetch_err_out <= 1'b0;
      sw_rdata_out <= 16'h0000;
    end else begin
      standard_identifier_out <= sid_w;
      remote_out <= remote_w;
      ext_out <= ext_w;
      extended_identifier_upper_out <= eidu_w;
      fetch_done_out <= done_reg;
      fetch_err_out <= err_reg;
      sw_rdata_out <= rdata_reg;
    end
  end

  // ==========================================================
  // Checks
  // Checks watch this block's flops, its inputs and fetch_ok only; the memory is never
  // looked at, since its contents stay unknown until software writes them.
  // Checks rest while reset_in is high; all flops settle on those edges.

  // Done pulse trails the request by the two flop stages
  fetch_latency_a: assert property (@(posedge clk_in) disable iff (reset_in)
    fetch_in |-> ##2 fetch_done_out) else $error("fetch done not two cycles later");

  // Done output is exactly the internal done flag, one edge on
  done_map_a: assert property (@(posedge clk_in) disable iff (reset_in)
    fetch_done_out == $past(done_reg)) else $error("done pulse mismatch");

  // Read-back output is the captured memory word, one edge on
  readback_a: assert property (@(posedge clk_in) disable iff (reset_in)
    sw_rdata_out == $past(rdata_reg)) else $error("read data mismatch");

  // A request past the configured buffer count is flagged
  range_err_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (fetch_in && !fetch_ok) |-> ##2 fetch_err_out) else $error("out of area fetch not flagged");

  // A request inside the area never raises the error pulse
  good_no_err_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (fetch_in && fetch_ok) |-> ##2 !fetch_err_out) else $error("good fetch flagged");

  // A refused request leaves the fetched words untouched
  refused_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (fetch_in && !fetch_ok) |=> ($stable(w0_reg) && $stable(w1_reg)))
    else $error("refused fetch changed words");

  // Area settings follow the software load
  area_load_a: assert property (@(posedge clk_in) disable iff (reset_in)
    area_we_in |=> (base_reg == $past(area_base_in) && bufs_reg == $past(area_bufs_in)))
    else $error("area settings not loaded");

  // An error pulse never comes without its done pulse
  err_with_done_a: assert property (@(posedge clk_in) disable iff (reset_in)
    fetch_err_out |-> fetch_done_out) else $error("error without done");

  // Unused top bits of word 0 never reach the decoder
  word0_top_a: assert property (@(posedge clk_in) disable iff (reset_in)
    w0_reg[15:13] == 3'h0) else $error("word0 upper bits not zero");

  // Standard identifier output mirrors its field
  sid_map_a: assert property (@(posedge clk_in) disable iff (reset_in)
    standard_identifier_out == $past(w0_reg[cmbl_pkg::SID_MSB:cmbl_pkg::SID_LSB]))
    else $error("standard identifier wrong");

  // Remote request flag mirrors its bit
  remote_map_a: assert property (@(posedge clk_in) disable iff (reset_in)
    remote_out == $past(w0_reg[1])) else $error("remote flag wrong");

  // Format flag mirrors its bit
  ext_map_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ext_out == $past(w0_reg[0])) else $error("format flag wrong");

  // Unused top bits of word 1 never reach the decoder
  word1_top_a: assert property (@(posedge clk_in) disable iff (reset_in)
    w1_reg[15:12] == 4'h0) else $error("word1 upper bits not zero");

  // Upper extended identifier output mirrors its field
  eidu_map_a: assert property (@(posedge clk_in) disable iff (reset_in)
    extended_identifier_upper_out == $past(w1_reg[cmbl_pkg::EIDU_MSB:0]))
    else $error("extended identifier wrong");
endmodule

// ==== verification/can_message_buffer_layout_test.sv ====
// Self-checking testbench for the message buffer identifier layout
`timescale 1ns/1ps
module can_message_buffer_layout_test;
  logic clk_in = 0, reset_in = 1, sw_we_in = 0, sw_re_in = 0, area_we_in = 0, fetch_in = 0;
  logic [10:0] sw_addr_in = '0, area_base_in = '0, area_bufs_in = '0, fetch_buf_in = '0;
  logic [15:0] sw_wdata_in = '0, sw_rdata_out;
  logic fetch_done_out, fetch_err_out, remote_out, ext_out;
  logic [10:0] standard_identifier_out;
  logic [11:0] extended_identifier_upper_out;
  int mismatches = 0, total_checks = 0;
  // ==========================================
  // Clock and design
  always #5 clk_in = ~clk_in;
  cmbl_top DUT (.clk_in(clk_in), .reset_in(reset_in), .sw_we_in(sw_we_in),
    .sw_re_in(sw_re_in), .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in),
    .sw_rdata_out(sw_rdata_out), .area_we_in(area_we_in), .area_base_in(area_base_in),
    .area_bufs_in(area_bufs_in), .fetch_in(fetch_in), .fetch_buf_in(fetch_buf_in),
    .fetch_done_out(fetch_done_out), .fetch_err_out(fetch_err_out),
    .standard_identifier_out(standard_identifier_out), .remote_out(remote_out),
    .ext_out(ext_out), .extended_identifier_upper_out(extended_identifier_upper_out));
  // ==========================================
  // Shared tasks; inputs move 1 ns after the edge
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    sw_we_in = 1; sw_addr_in = a; sw_wdata_in = d;
    tick(1);
    sw_we_in = 0;
    tick(1);
  endtask
  // Read data lands two cycles after the strobe
  task automatic rd_chk(input logic [10:0] a, input logic [15:0] exp);
    sw_re_in = 1; sw_addr_in = a;
    tick(1);
    sw_re_in = 0;
    tick(1);
    cmp(sw_rdata_out, exp);
  endtask
  // Fields are packed sid, remote, ext, upper extended id
  task automatic fetch_chk(input logic [10:0] b, input logic err, input logic [24:0] exp);
    fetch_in = 1; fetch_buf_in = b;
    tick(1);
    fetch_in = 0;
    tick(1);
    cmp({fetch_done_out, fetch_err_out}, {1'b1, err});
    cmp({standard_identifier_out, remote_out, ext_out, extended_identifier_upper_out}, exp);
    tick(1);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_fields;
    area_we_in = 1; area_base_in = 11'h100; area_bufs_in = 11'h004;
    tick(1);
    area_we_in = 0;
    wr(11'h100, 16'hFFFF);
    wr(11'h101, 16'hF555);
    wr(11'h108, 16'h0001);
    wr(11'h109, 16'h0800);
    wr(11'h118, 16'hE5AA);
    wr(11'h119, 16'h1000);
    tick(1);
    fetch_chk(11'h000, 1'b0, {11'h7FF, 1'b1, 1'b1, 12'h555});
    fetch_chk(11'h001, 1'b0, {11'h000, 1'b0, 1'b1, 12'h800});
    fetch_chk(11'h003, 1'b0, {11'h16A, 1'b1, 1'b0, 12'h000});
    rd_chk(11'h118, 16'hE5AA);
    fetch_chk(11'h004, 1'b1, {11'h16A, 1'b1, 1'b0, 12'h000});
  endtask
  // Small area wrapping at the top of memory
  task automatic t_wrap;
    area_we_in = 1; area_base_in = 11'h7F8; area_bufs_in = 11'h002;
    tick(1);
    area_we_in = 0;
    wr(11'h000, 16'h0006);
    wr(11'h001, 16'h0ABC);
    tick(1);
    fetch_chk(11'h001, 1'b0, {11'h001, 1'b1, 1'b0, 12'hABC});
    fetch_chk(11'h002, 1'b1, {11'h001, 1'b1, 1'b0, 12'hABC});
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    tick(3);
    reset_in = 0;
    cmp({fetch_done_out, standard_identifier_out, extended_identifier_upper_out}, 32'h0);
    t_fields;
    t_wrap;
    report_and_stop;
  end
  initial begin
    #20000;
    mismatches++;
    report_and_stop;
  end
endmodule
